// ===== include/ipsr_consts.vh
// register offsets, field positions, reset values and codes for the priority/sense block
// assumes a plain word-indexed register port of 16-bit data
`ifndef IPSR_CONSTS_VH
`define IPSR_CONSTS_VH

// register indices (chosen, no printed offsets)
`define IPSR_ADDR_W        4
`define IPSR_IDX_PRI_A     4'h0
`define IPSR_IDX_PRI_B     4'h1
`define IPSR_IDX_PRI_C     4'h2
`define IPSR_IDX_PRI_D     4'h3
`define IPSR_IDX_PRI_E     4'h4
`define IPSR_IDX_PRI_F     4'h5
`define IPSR_IDX_PRI_G     4'h6
`define IPSR_IDX_NMCTL     4'h7
`define IPSR_IDX_EXTCTL    4'h8
`define IPSR_IDX_PORTCTL   4'h9
`define IPSR_IDX_CARDMSK   4'hA
`define IPSR_IDX_EVCODE    4'hB
`define IPSR_IDX_ISTAT     4'hC
`define IPSR_IDX_IMASK     4'hD

// reset values
`define IPSR_RST_ZERO      16'h0000
`define IPSR_RST_EXTCTL    16'h4000

// writable masks (reserved bits read zero)
`define IPSR_WMASK_FULL    16'hFFFF
`define IPSR_WMASK_PRI_B   16'hFFF0
`define IPSR_WMASK_PRI_E   16'hF0FF
`define IPSR_WMASK_PRI_F   16'h0FFF
`define IPSR_WMASK_NMCTL   16'h0100
`define IPSR_WMASK_EXTCTL  16'hEFFF
`define IPSR_WMASK_CARD    16'h7F00

// field positions
`define IPSR_BIT_NM_LEVEL  15
`define IPSR_BIT_NM_EDGE   8
`define IPSR_BIT_MASK_ALL  15
`define IPSR_BIT_ENC_SEL   14
`define IPSR_BIT_BLK_OVR   13
`define IPSR_CARD_LSB      8

// sense encodings
`define IPSR_SENSE_FALL    2'h0
`define IPSR_SENSE_RISE    2'h1
`define IPSR_SENSE_LOW     2'h2

// event codes
`define IPSR_EVT_BASE      12'h200
`define IPSR_EVT_STEP      12'h020
`define IPSR_EVT_NM        12'h1C0
`define IPSR_LVL_MAX       4'hF

// status bits: 0 nonmaskable edge, 1..6 request pins 0..5
`define IPSR_NSTAT         7
`endif

// ===== hdl/ipsr_regs.v
// priority, sense and mask registers of the interrupt controller, with pin sensing
// assumes a single 20 MHz clock, sync active-low reset, pins asynchronous to clk_sys
//
// Functional notes
// - encoded level n reports code 0x200+(15-n)*0x20
// - equal levels resolve by fixed source order
// - seven 16-bit priority registers, reset zero
// - contents kept in standby; only reset clears
// - four 4-bit level fields, zero means masked
// - fields mapped to source groups per register
// - reserved priority fields read as zero
// - bit 15 reads live nonmaskable pin level
// - bit 8 selects nonmaskable falling/rising edge
// - mask-all masks requests while nonmaskable low
// - bit 14 selects encoded level pins, resets one
// - bit 13 overrides block bit for nonmaskable
// - two-bit sense per request pin, falling default
// - per-port-pin sense bit, low level default
// - card cause masks bits 14..8, zero masks
// - reserved control bits read as zero
// - nonmaskable control only edge bit writable
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "ipsr_consts.vh"

module ipsr_regs (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        nonmaskable_pin,
    input  wire [5:0]  ext_request_pin,
    input  wire [15:0] port_change_pin,
    input  wire [6:0]  card_cause_in,
    input  wire        processor_block_bit,
    input  wire        standby,
    output wire        nonmaskable_req,
    output wire        all_masked,
    output wire [5:0]  ext_req,
    output wire [15:0] port_req,
    output wire [6:0]  card_req,
    output reg  [3:0]  enc_level,
    output reg  [11:0] event_code,
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [15:0] pri_q [0:6];        // priority registers a..g
    reg         nm_edge_q;          // nonmaskable edge select
    reg  [15:0] ext_ctl_q;          // external sense control
    reg  [15:0] port_ctl_q;         // port sense control
    reg  [15:0] card_msk_q;         // card cause mask
    reg  [6:0]  stat_q;             // sticky event status
    reg  [6:0]  imask_q;            // interrupt mask
    reg  [6:0]  ext_edge_q;         // edge-latched request pins (bits 1..6; bit 0 nonmaskable)
    reg  [22:0] sync1_q;            // first synchroniser stage
    reg  [22:0] sync2_q;            // second stage, safe to read
    reg  [22:0] prev_q;             // previous synced value for edges
    reg  [6:0]  stat_d;             // next status
    reg  [6:0]  evt;                // this cycle's events
    reg  [5:0]  lvl_req;            // level-sensed request pins
    integer     i;                  // loop index, register reset only
    integer     j;                  // loop index, pin sensing only

    // synced views
    wire        nm_s   = sync2_q[22];
    wire        nm_p   = prev_q[22];
    wire [5:0]  ext_s  = sync2_q[21:16];
    wire [5:0]  ext_p  = prev_q[21:16];
    wire [15:0] port_s = sync2_q[15:0];

    ////////////////////////////////////////////////////////////////////////
    // functions

    // priority field n of register r
    function [3:0] pri_field;
        input [15:0] r;
        input [1:0]  n;
        begin
            pri_field = r[n*4 +: 4];
        end
    endfunction

    // event code for an encoded level
    function [11:0] lvl_code;
        input [3:0] lvl;
        begin
            lvl_code = `IPSR_EVT_BASE + {3'h0, (`IPSR_LVL_MAX - lvl), 5'h00};
        end
    endfunction

    // write mask per priority register index
    function [15:0] wmask;
        input [3:0] a;
        begin
            case (a)
                `IPSR_IDX_PRI_B: wmask = `IPSR_WMASK_PRI_B;
                `IPSR_IDX_PRI_E: wmask = `IPSR_WMASK_PRI_E;
                `IPSR_IDX_PRI_F: wmask = `IPSR_WMASK_PRI_F;
                default:         wmask = `IPSR_WMASK_FULL;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_q <= 23'h000000;
            sync2_q <= 23'h000000;
            prev_q  <= 23'h000000;
        end else begin
            sync1_q <= {nonmaskable_pin, ext_request_pin, port_change_pin};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes; standby does not touch them
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            for (i = 0; i < 7; i = i + 1) begin
                pri_q[i] <= `IPSR_RST_ZERO;
            end
            nm_edge_q  <= 1'b0;
            ext_ctl_q  <= `IPSR_RST_EXTCTL;
            port_ctl_q <= `IPSR_RST_ZERO;
            card_msk_q <= `IPSR_RST_ZERO;
            imask_q    <= 7'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                `IPSR_IDX_PRI_A, `IPSR_IDX_PRI_B, `IPSR_IDX_PRI_C, `IPSR_IDX_PRI_D,
                `IPSR_IDX_PRI_E, `IPSR_IDX_PRI_F, `IPSR_IDX_PRI_G: begin
                    pri_q[reg_addr[2:0]] <= reg_wdata & wmask(reg_addr);
                end
                `IPSR_IDX_NMCTL: begin
                    nm_edge_q <= reg_wdata[`IPSR_BIT_NM_EDGE];
                end
                `IPSR_IDX_EXTCTL: begin
                    ext_ctl_q <= reg_wdata & `IPSR_WMASK_EXTCTL;
                end
                `IPSR_IDX_PORTCTL: begin
                    port_ctl_q <= reg_wdata;
                end
                `IPSR_IDX_CARDMSK: begin
                    card_msk_q <= reg_wdata & `IPSR_WMASK_CARD;
                end
                `IPSR_IDX_IMASK: begin
                    imask_q <= reg_wdata[6:0];
                end
                default: begin
                    // read-only or unmapped: ignored
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge and level sensing of pins
    always @* begin
        evt = 7'h00;
        // nonmaskable edge, polarity from edge select
        if (nm_edge_q) begin
            evt[0] = nm_s & ~nm_p;
        end else begin
            evt[0] = ~nm_s & nm_p;
        end
        lvl_req = 6'h00;
        for (j = 0; j < 6; j = j + 1) begin
            case (ext_ctl_q[j*2 +: 2])
                `IPSR_SENSE_FALL: evt[j+1] = ~ext_s[j] & ext_p[j];
                `IPSR_SENSE_RISE: evt[j+1] = ext_s[j] & ~ext_p[j];
                `IPSR_SENSE_LOW:  lvl_req[j] = ~ext_s[j];
                default:          lvl_req[j] = 1'b0;        // reserved: no request
            endcase
        end
    end

    // edge latch per request pin, cleared by status clear
    always @* begin
        stat_d = stat_q;
        if (reg_wr && reg_addr == `IPSR_IDX_ISTAT) begin
            stat_d = stat_q & ~reg_wdata[6:0];
        end
        stat_d = stat_d | evt;                              // set beats clear
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_q     <= 7'h00;
            ext_edge_q <= 7'h00;
        end else begin
            stat_q     <= stat_d;
            ext_edge_q <= stat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request outputs to the core

    // mask-all: while nonmaskable is low the request pin, port and card requests are held off
    assign all_masked = ext_ctl_q[`IPSR_BIT_MASK_ALL] & ~nm_s;

    // nonmaskable masked by block bit unless overridden, and in standby while mask-all is set
    assign nonmaskable_req = ext_edge_q[0]
                           & (ext_ctl_q[`IPSR_BIT_BLK_OVR] | ~processor_block_bit)
                           & ~(ext_ctl_q[`IPSR_BIT_MASK_ALL] & standby);

    // pins 3..0 are encoded level inputs when encoded select is set
    assign ext_req = ({6{~all_masked}} & (ext_edge_q[6:1] | lvl_req))
                   & {2'b11, {4{~ext_ctl_q[`IPSR_BIT_ENC_SEL]}}};

    // port pins active at the selected level
    assign port_req = {16{~all_masked}} & ~(port_s ^ port_ctl_q);

    // card causes gated by their mask bits
    assign card_req = {7{~all_masked}} & card_cause_in
                    & card_msk_q[`IPSR_CARD_LSB +: 7];

    assign irq = |(stat_q & imask_q);

    ////////////////////////////////////////////////////////////////////////
    // arbitration: highest level wins, ties by fixed order (pins 0..3, then 5, 4, ports, card)
    always @(posedge clk_sys) begin : arb
        reg [3:0]  best;
        reg [11:0] code;
        reg [3:0]  lv;
        integer    s;
        best = 4'h0;
        code = 12'h000;
        lv   = 4'h0;
        s    = 0;
        if (!rst_n) begin
            enc_level  <= 4'h0;
            event_code <= 12'h000;
        end else begin
            if (ext_ctl_q[`IPSR_BIT_ENC_SEL] && !all_masked) begin
                // encoded pins are active low: 0000 is level 15
                lv = ~ext_s[3:0];
                if (lv != 4'h0) begin
                    best = lv;
                    code = lvl_code(lv);
                end
            end else begin
                // independent pins 3..0, fixed order pin 0 first on ties
                for (s = 3; s >= 0; s = s - 1) begin
                    lv = pri_field(pri_q[2], s[1:0]);
                    if (ext_req[s] && lv != 4'h0 && lv >= best) begin
                        best = lv;
                        code = lvl_code(lv);
                    end
                end
            end
            // pins 5,4 then port groups from register d
            for (s = 1; s >= 0; s = s - 1) begin
                lv = pri_field(pri_q[3], s[1:0]);
                if (ext_req[s+4] && lv != 4'h0 && lv > best) begin
                    best = lv;
                    code = lvl_code(lv);
                end
            end
            lv = pri_field(pri_q[3], 2'd3);
            if ((|port_req[7:0]) && lv != 4'h0 && lv > best) begin
                best = lv;
                code = lvl_code(lv);
            end
            lv = pri_field(pri_q[3], 2'd2);
            if ((|port_req[15:8]) && lv != 4'h0 && lv > best) begin
                best = lv;
                code = lvl_code(lv);
            end
            // card controller group in register f bits 7..4
            lv = pri_field(pri_q[5], 2'd1);
            if ((|card_req) && lv != 4'h0 && lv > best) begin
                best = lv;
                code = lvl_code(lv);
            end
            if (nonmaskable_req) begin
                best = `IPSR_LVL_MAX;
                code = `IPSR_EVT_NM;
            end
            enc_level  <= best;
            event_code <= code;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `IPSR_IDX_PRI_A, `IPSR_IDX_PRI_B, `IPSR_IDX_PRI_C, `IPSR_IDX_PRI_D,
                `IPSR_IDX_PRI_E, `IPSR_IDX_PRI_F, `IPSR_IDX_PRI_G: begin
                    reg_rdata <= pri_q[reg_addr[2:0]];
                end
                `IPSR_IDX_NMCTL: begin
                    reg_rdata <= {nm_s, 6'h00, nm_edge_q, 8'h00};
                end
                `IPSR_IDX_EXTCTL:  reg_rdata <= ext_ctl_q;
                `IPSR_IDX_PORTCTL: reg_rdata <= port_ctl_q;
                `IPSR_IDX_CARDMSK: reg_rdata <= card_msk_q;
                `IPSR_IDX_EVCODE:  reg_rdata <= {4'h0, event_code};
                `IPSR_IDX_ISTAT:   reg_rdata <= {9'h000, stat_q};
                `IPSR_IDX_IMASK:   reg_rdata <= {9'h000, imask_q};
                default:           reg_rdata <= 16'h0000; // unmapped reads zero
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // ipsr_regs

// ===== test/ipsr_regs_asserts.sv
// assertion checker for ipsr_regs, watching its ports only
// assumes the index map and reset values of ipsr_consts.vh
`timescale 1ns/1ns
`include "ipsr_consts.vh"
module ipsr_regs_asserts (
    input wire        clk_sys,
    input wire        rst_n,
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire        nonmaskable_pin,
    input wire [15:0] port_change_pin,
    input wire [6:0]  card_cause_in,
    input wire        processor_block_bit,
    input wire        standby,
    input wire        nonmaskable_req,
    input wire        all_masked,
    input wire [5:0]  ext_req,
    input wire [15:0] port_req,
    input wire [6:0]  card_req,
    input wire [3:0]  enc_level,
    input wire [11:0] event_code
);
    reg [15:0] ext_q;  // shadow of the sense control word
    reg [15:0] port_q; // shadow of the port sense word
    reg [15:0] card_q; // shadow of the card mask word
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////
    // shadows track software writes, masked as the block masks them
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_q  <= `IPSR_RST_EXTCTL;
            port_q <= `IPSR_RST_ZERO;
            card_q <= `IPSR_RST_ZERO;
        end else if (reg_wr) begin
            if (reg_addr == `IPSR_IDX_EXTCTL) ext_q <= reg_wdata & 16'hEFFF;
            if (reg_addr == `IPSR_IDX_PORTCTL) port_q <= reg_wdata;
            if (reg_addr == `IPSR_IDX_CARDMSK) card_q <= reg_wdata & 16'h7F00;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_ext_readback;
        reg_rd && reg_addr == `IPSR_IDX_EXTCTL |=> reg_rdata == $past(ext_q);
    endproperty
    a_ext_readback: assert property (p_ext_readback) else $error("sense word readback");
    property p_nm_reserved;
        reg_rd && reg_addr == `IPSR_IDX_NMCTL |=> (reg_rdata & 16'h7EFF) == 16'h0000;
    endproperty
    a_nm_reserved: assert property (p_nm_reserved) else $error("nm word reserved bit");
    property p_card;
        card_req == (card_cause_in & card_q[14:8] & {7{!all_masked}});
    endproperty
    a_card: assert property (p_card) else $error("card request mask");
    property p_enc_quiet;
        ext_q[14] |-> ext_req[3:0] == 4'h0;
    endproperty
    a_enc_quiet: assert property (p_enc_quiet) else $error("pins 3..0 in encoded mode");
    property p_block;
        processor_block_bit && !ext_q[13] |-> !nonmaskable_req;
    endproperty
    a_block: assert property (p_block) else $error("nm passed block bit");
    property p_standby;
        standby && ext_q[15] |-> !nonmaskable_req;
    endproperty
    a_standby: assert property (p_standby) else $error("nm passed in standby");
    // three cycles of steady input cover the synchroniser delay
    property p_mask_all;
        (ext_q[15] && !nonmaskable_pin)[*3] |-> all_masked;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("mask all missing");
    property p_port;
        ($stable(port_change_pin) && !all_masked && $past(rst_n, 3))[*3]
            |-> port_req == ~(port_change_pin ^ port_q);
    endproperty
    a_port: assert property (p_port) else $error("port sense");
    property p_event;
        event_code != 12'h000 && event_code != `IPSR_EVT_NM
            |-> enc_level != 4'h0 && event_code == 12'h200 + {3'h0, 4'hF - enc_level, 5'h00};
    endproperty
    a_event: assert property (p_event) else $error("event code vs level");
    c_nm: cover property (nonmaskable_req);
    c_top: cover property (event_code == 12'h200);
    c_mask: cover property (all_masked);
endmodule // ipsr_regs_asserts

// ===== test/ipsr_src_model.sv
// far-side model: pin levels and core levels seen by the block
// assumes the bench sets wanted levels; pins land mid-cycle
`timescale 1ns/1ns
module ipsr_src_model (
    input  wire        clk_sys,
    input  wire        slow,
    input  wire [22:0] want_pins,
    input  wire [8:0]  want_core,
    output reg  [22:0] pins,
    output reg  [8:0]  core
);
    initial pins = 23'h7FFFFF;
    initial core = 9'h000;
    // core levels move with the clock
    always @(posedge clk_sys) core <= want_core;
    // pins move off the clock edge, slowly or promptly
    always @(want_pins) pins <= #(slow ? 37 : 13) want_pins;
endmodule // ipsr_src_model

// ===== test/ipsr_regs_tb_top.sv
// self-checking bench for ipsr_regs
// assumes 20 MHz clk_sys, sync active-low reset, source model on pins
`timescale 1ns/1ns
`include "ipsr_consts.vh"
bind ipsr_regs ipsr_regs_asserts i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .nonmaskable_pin(nonmaskable_pin),
    .port_change_pin(port_change_pin), .card_cause_in(card_cause_in),
    .processor_block_bit(processor_block_bit), .standby(standby),
    .nonmaskable_req(nonmaskable_req), .all_masked(all_masked), .ext_req(ext_req),
    .port_req(port_req), .card_req(card_req), .enc_level(enc_level),
    .event_code(event_code));
module ipsr_regs_tb_top;
    reg         clk_sys   = 1'b0;
    reg         rst_n     = 1'b0;
    reg  [3:0]  reg_addr  = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr    = 1'b0;
    reg         reg_rd    = 1'b0;
    reg         slow      = 1'b0;       // source model speed
    reg  [22:0] want_pins = 23'h7FFFFF; // nm, request pins, port pins
    reg  [8:0]  want_core = 9'h000;     // standby, block bit, card causes
    reg         rd_seen   = 1'b0;       // read data due now
    reg  [15:0] exp_q[$];               // expected read data
    reg  [15:0] mem[0:10];              // last word kept per index
    reg  [15:0] d;
    wire [22:0] pins;
    wire [8:0]  core;
    wire [15:0] reg_rdata;
    wire [15:0] port_req;
    wire [5:0]  ext_req;
    wire [6:0]  card_req;
    wire [3:0]  enc_level;
    wire [11:0] event_code;
    wire        nonmaskable_req;
    wire        all_masked;
    wire        irq;
    integer     bad_count = 0;
    integer     samples_checked = 0;
    integer     i;
    integer     k;
    ipsr_src_model i_src (.clk_sys(clk_sys), .slow(slow), .want_pins(want_pins),
        .want_core(want_core), .pins(pins), .core(core));
    ipsr_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nonmaskable_pin(pins[22]), .ext_request_pin(pins[21:16]),
        .port_change_pin(pins[15:0]), .card_cause_in(core[6:0]),
        .processor_block_bit(core[7]), .standby(core[8]),
        .nonmaskable_req(nonmaskable_req), .all_masked(all_masked), .ext_req(ext_req),
        .port_req(port_req), .card_req(card_req), .enc_level(enc_level),
        .event_code(event_code), .irq(irq));
    ////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] expd, input string what);
        samples_checked = samples_checked + 1;
        if (seen !== expd) begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %h seen %h", what, expd, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // writable bits per index; reserved bits read zero
    function [15:0] wmask(input [3:0] a);
        case (a)
            4'h1: wmask = 16'hFFF0;
            4'h4: wmask = 16'hF0FF;
            4'h5: wmask = 16'h0FFF;
            4'h7: wmask = 16'h0100;
            4'h8: wmask = 16'hEFFF;
            4'hA: wmask = 16'h7F00;
            default: wmask = 16'hFFFF;
        endcase
    endfunction
    // bus cycles start on a rising edge, never both strobes at once
    task wr(input [3:0] a, input [15:0] v);
        if (!clk_sys) @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rd(input [3:0] a, input [15:0] e);
        if (!clk_sys) @(posedge clk_sys);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge clk_sys);
    endtask
    // idle n cycles, end mid-cycle where outputs are settled
    task gap(input integer n);
        if (!clk_sys) @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task wait_irq(input lvl);
        integer t;
        gap(1);
        for (t = 0; t < 40 && irq !== lvl; t = t + 1) @(negedge clk_sys);
        check(irq, lvl, "irq");
        if (irq !== lvl) give_verdict;
    endtask
    ////////////////////////////////////////////////////////////
    // read monitor: oldest expectation against the answer cycle
    always @(posedge clk_sys) rd_seen <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_seen && exp_q.size() == 0) check(1, 0, "read queue");
        else if (rd_seen) check(reg_rdata, exp_q.pop_front(), "reg_rdata");
    end
    initial forever #25 clk_sys = ~clk_sys;
    initial begin
        k = $urandom(32'hFBD47921);
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset words; nm pin idles high
        for (i = 0; i < 16; i = i + 1)
            rd(i[3:0], i == 8 ? 16'h4000 : i == 7 ? 16'h8000 : 16'h0000);
        // all ones, then random words, back to back
        for (k = 0; k < 2; k = k + 1)
            for (i = 0; i < 11; i = i + 1) begin
                d = k ? $urandom : 16'hFFFF;
                mem[i] = d & wmask(i[3:0]);
                wr(i[3:0], d);
                rd(i[3:0], mem[i] | (i == 7 ? 16'h8000 : 16'h0000));
            end
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        // standby keeps every word
        gap(1);
        want_core <= 9'h100;
        gap(4);
        for (i = 0; i < 11; i = i + 1)
            rd(i[3:0], mem[i] | (i == 7 ? 16'h8000 : 16'h0000));
        // nm falling edge raises, mask and clear drop the interrupt
        wr(`IPSR_IDX_NMCTL, 16'h0000);
        wr(`IPSR_IDX_EXTCTL, 16'h2000);
        wr(`IPSR_IDX_PORTCTL, 16'h0000);
        wr(`IPSR_IDX_CARDMSK, 16'h0000);
        wr(`IPSR_IDX_IMASK, 16'h0001);
        wr(`IPSR_IDX_ISTAT, 16'hFFFF);
        want_core <= 9'h000;
        want_pins[22] <= 1'b0;
        wait_irq(1'b1);
        check(nonmaskable_req, 1, "nm request");
        rd(`IPSR_IDX_NMCTL, 16'h0000);
        rd(`IPSR_IDX_ISTAT, 16'h0001);
        wr(`IPSR_IDX_IMASK, 16'h0000);
        wait_irq(1'b0);
        wr(`IPSR_IDX_ISTAT, 16'h0001);
        wr(`IPSR_IDX_IMASK, 16'h0001);
        gap(6);
        check(irq, 0, "held pin, no edge");
        wr(`IPSR_IDX_NMCTL, 16'h0100);
        want_pins[22] <= 1'b1;
        wait_irq(1'b1);
        rd(`IPSR_IDX_NMCTL, 16'h8100);
        wr(`IPSR_IDX_EXTCTL, 16'h0000);
        want_core <= 9'h080;
        gap(3);
        check(nonmaskable_req, 0, "nm blocked");
        wr(`IPSR_IDX_EXTCTL, 16'h8000);
        want_core <= 9'h000;
        want_pins[22] <= 1'b0;
        gap(8);
        check(all_masked, 1, "mask all");
        want_core <= 9'h100;
        gap(3);
        check(nonmaskable_req, 0, "nm in standby");
        // encoded pins: each value 0..14 gives its own level and code
        want_core <= 9'h000;
        want_pins[22] <= 1'b1;
        gap(8);
        wr(`IPSR_IDX_EXTCTL, 16'h4000);
        wr(`IPSR_IDX_ISTAT, 16'hFFFF);
        for (i = 0; i < 15; i = i + 1) begin
            want_pins[19:16] <= i[3:0];
            slow <= $urandom;
            gap(8);
            check(event_code, 12'h200 + i * 12'h20, "event code");
            check(enc_level, 15 - i, "level");
            check(ext_req[3:0], 0, "encoded pins");
        end
        // pin 5 rising, pin 4 low level, pin 3 falling
        want_pins[19:16] <= 4'hF;
        wr(`IPSR_IDX_EXTCTL, 16'h0600);
        gap(8);
        wr(`IPSR_IDX_ISTAT, 16'hFFFF);
        want_pins[21:19] <= 3'b000;
        gap(8);
        check(ext_req[5:3], 3'b011, "fall and low");
        want_pins[21:19] <= 3'b110;
        gap(8);
        check(ext_req[5:3], 3'b101, "rise and latch");
        wr(`IPSR_IDX_ISTAT, 16'h0050);
        gap(2);
        check(ext_req[5:3], 3'b000, "latch cleared");
        // port sense and card masks with random words
        wr(`IPSR_IDX_EXTCTL, 16'h0000);
        for (i = 0; i < 6; i = i + 1) begin
            d = $urandom;
            wr(`IPSR_IDX_PORTCTL, d);
            wr(`IPSR_IDX_CARDMSK, d);
            want_pins[15:0] <= $urandom;
            want_core <= $urandom;
            gap(8);
            check(port_req, 16'(~(want_pins[15:0] ^ d)), "port");
            check(card_req, want_core[6:0] & d[14:8], "card");
        end
        gap(2);
        give_verdict;
    end
endmodule // ipsr_regs_tb_top
